// ### hdl/ida_pkg.sv
// constants, types and the function list for the indirect data addressing block
//
// Function
// (RQ1) indirect port accesses act on the location held by its pointer
// (RQ2) port zero with pointer_zero reaches only sector 0
// (RQ3) ports one and two reach any sector: high byte sector, low byte offset
// (RQ4) indirect ports store nothing: read 00H, write does nothing
// (RQ5) all five pointer bytes are ordinary readable, writable, incrementable registers
// (RQ6) extended direct addresses: upper bits give sector, low eight the offset
// (RQ7) bank_select_bit chooses program bank, zero after reset
// (RQ8) bank select bits 7 to 1 read as zero
// (RQ9) jump or call lands in the bank chosen by bank_select_bit
// (RQ10) alu results go to accumulator, no register to register move; inc writes its result back to the location instead
// (RQ11) pc_low_byte is readable and writable in the special area
// (RQ12) writing pc_low_byte jumps within current page, upper bits kept
// (RQ13) a pc_low_byte write inserts one dummy cycle
// (RQ14) pointer low byte increments wrap in eight bits, no sector carry
package ida_pkg;

  // ---------------------------------------------------------------
  // data memory geometry
  // ---------------------------------------------------------------
  localparam int          SECT_W    = 1;             // two sectors
  localparam int          DADDR_W   = 8 + SECT_W;    // extended data address
  localparam int          PC_W      = 13;            // bank bit plus 12 bits
  localparam int          PAGE_LSB  = 8;

  // ---------------------------------------------------------------
  // special register offsets inside a sector
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFF_PORT0 = 8'h00;
  localparam logic [7:0]  OFF_PTR0  = 8'h01;
  localparam logic [7:0]  OFF_PORT1 = 8'h02;
  localparam logic [7:0]  OFF_P1LO  = 8'h03;
  localparam logic [7:0]  OFF_P1SEC = 8'h04;
  localparam logic [7:0]  OFF_ACC   = 8'h05;
  localparam logic [7:0]  OFF_PCL   = 8'h06;
  localparam logic [7:0]  OFF_BANK  = 8'h0B;
  localparam logic [7:0]  OFF_PORT2 = 8'h0C;
  localparam logic [7:0]  OFF_P2LO  = 8'h0D;
  localparam logic [7:0]  OFF_P2SEC = 8'h0E;
  localparam logic [3:0]  SPECIAL_HI = 4'h0;         // offsets 00H..0FH

  // ---------------------------------------------------------------
  // bus map: bit 11 low selects data memory, high selects control
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD  = 12'h800;
  localparam logic [11:0] ADDR_STAT = 12'h804;
  localparam int          CTRL_BIT  = 11;

  // command word fields
  localparam int          CMD_OP_LSB = 16;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 13'h0000;

  // cycles of the single dummy cycle after a pc_low_byte write
  localparam int          DUMMY_CYC = 1;

  typedef enum logic [3:0] {
    IDA_OP_NOP,
    IDA_OP_LOAD,
    IDA_OP_STORE,
    IDA_OP_ADD,
    IDA_OP_INC,
    IDA_OP_JUMP,
    IDA_OP_CALL
  } ida_op_t;

  typedef enum logic [1:0] {
    IDA_IDLE,
    IDA_ACCESS,
    IDA_DUMMY
  } ida_state_t;

endpackage : ida_pkg

// ### hdl/ida_dmem.sv
// general purpose data memory, all sectors, one write port, one read port
`timescale 1ns/100ps
module ida_dmem
  import ida_pkg::*;
(
  input  wire logic               clk_sys,  // system clock
  input  wire logic               we,       // write strobe
  input  wire logic [DADDR_W-1:0] addr,     // sector and offset
  input  wire logic [7:0]         wdata,    // write byte
  output logic      [7:0]         rdata     // read byte, same cycle
);

  logic [7:0] mem_q [0:(1<<DADDR_W)-1];

  // synchronous write, contents undefined after reset like plain ram
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
    end
  end

  // combinational read
  assign rdata = mem_q[addr];

endmodule : ida_dmem

// ### hdl/ida_core.sv
// indirect addressing, pointers, bank select, accumulator and pc low byte
`timescale 1ns/100ps
module ida_core
  import ida_pkg::*;
(
  input  wire logic        clk_sys,     // 25 MHz system clock
  input  wire logic        reset,       // async reset, active high
  input  wire logic        hsel,        // ahb slave select
  input  wire logic [31:0] haddr,       // ahb address
  input  wire logic [1:0]  htrans,      // ahb transfer type
  input  wire logic        hwrite,      // ahb write
  input  wire logic [2:0]  hsize,       // ahb size, word only
  input  wire logic [31:0] hwdata,      // ahb write data
  input  wire logic        hready,      // ahb bus ready
  output logic      [31:0] hrdata,      // ahb read data
  output logic             hreadyout,   // ahb slave ready
  output logic             hresp,       // ahb response, always okay
  output logic             bank_select, // current program bank
  output logic [PC_W-1:0]  pc_out       // program counter
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ida_state_t       state;
    logic [11:0]      addr;
    logic             write;
    logic [7:0]       ptr0;
    logic [7:0]       p1_lo;
    logic [7:0]       p1_sec;
    logic [7:0]       p2_lo;
    logic [7:0]       p2_sec;
    logic [7:0]       acc;
    logic             bank;
    logic [PC_W-1:0]  pc;
    logic [7:0]       dummy_cnt;
    logic [31:0]      rdata;
    logic             ready;
    logic             resp;
  } ida_regs_t;

  ida_regs_t              s_reg;
  ida_regs_t              s_next;
  logic                   mem_we;
  logic [DADDR_W-1:0]     mem_addr;
  logic [7:0]             mem_wdata;
  logic [7:0]             mem_rdata;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // offsets 00H..0FH of each sector hold the special registers
  function automatic logic is_special(input logic [DADDR_W-1:0] a);
    is_special = (a[7:4] == SPECIAL_HI);
  endfunction : is_special

  // map an indirect port to the location its pointer names
  function automatic logic [DADDR_W-1:0] resolve(input logic [DADDR_W-1:0] a,
                                                 input ida_regs_t r);
    resolve = a;
    if (is_special(a))
    begin
      case (a[7:0])
        OFF_PORT0: resolve = {{SECT_W{1'b0}}, r.ptr0};           // [RQ1] [RQ2]
        OFF_PORT1: resolve = {r.p1_sec[SECT_W-1:0], r.p1_lo};    // [RQ1] [RQ3]
        OFF_PORT2: resolve = {r.p2_sec[SECT_W-1:0], r.p2_lo};    // [RQ1] [RQ3]
        default:   resolve = a;                                  // [RQ6]
      endcase
    end
  endfunction : resolve

  // read of a resolved location
  function automatic logic [7:0] read_loc(input logic [DADDR_W-1:0] a,
                                          input ida_regs_t r,
                                          input logic [7:0] m);
    read_loc = m;
    if (is_special(a))
    begin
      case (a[7:0])
        OFF_PTR0:  read_loc = r.ptr0;                            // [RQ5]
        OFF_P1LO:  read_loc = r.p1_lo;
        OFF_P1SEC: read_loc = r.p1_sec;
        OFF_P2LO:  read_loc = r.p2_lo;
        OFF_P2SEC: read_loc = r.p2_sec;
        OFF_ACC:   read_loc = r.acc;
        OFF_PCL:   read_loc = r.pc[7:0];                         // [RQ11]
        OFF_BANK:  read_loc = {7'h00, r.bank};                   // [RQ8]
        default:   read_loc = RST_BYTE;                          // [RQ4]
      endcase
    end
  endfunction : read_loc

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [DADDR_W-1:0] eff;
    logic               wr_en;
    logic [7:0]         wr_data;
    logic [7:0]         rd_val;
    ida_op_t            op;
    logic [PC_W-1:0]    target;
    s_next    = s_reg;
    eff       = resolve(s_reg.addr[DADDR_W+1:2], s_reg);
    wr_en     = 1'b0;
    wr_data   = hwdata[7:0];
    rd_val    = 8'h00;
    op        = IDA_OP_NOP;
    target    = hwdata[PC_W-1:0];
    mem_we    = 1'b0;
    mem_wdata = wr_data;
    s_next.resp = 1'b0;
    if (s_reg.addr[CTRL_BIT] && s_reg.addr == ADDR_CMD)
    begin
      eff = resolve(hwdata[DADDR_W-1:0], s_reg);
      op  = ida_op_t'(hwdata[CMD_OP_LSB+3:CMD_OP_LSB]);
    end
    mem_addr = eff;
    rd_val   = read_loc(eff, s_reg, mem_rdata);

    case (s_reg.state)
      // take an address phase when the bus is ready
      IDA_IDLE:
      begin
        s_next.ready = 1'b1;
        if (hsel && htrans[1] && hready)
        begin
          s_next.addr  = haddr[11:0];
          s_next.write = hwrite;
          s_next.ready = 1'b0;
          s_next.state = IDA_ACCESS;
        end
      end

      // data phase: perform the access, then release the bus, except after a pc low byte write
      IDA_ACCESS:
      begin
        s_next.ready = 1'b1;
        s_next.state = IDA_IDLE;
        s_next.rdata = 32'h0000_0000;
        if (!s_reg.addr[CTRL_BIT])
        begin
          if (s_reg.write)
          begin
            wr_en = 1'b1;                                        // [RQ1]
          end
          else
          begin
            s_next.rdata = {24'h00_0000, rd_val};                // [RQ1]
          end
        end
        else if (s_reg.addr == ADDR_STAT && !s_reg.write)
        begin
          s_next.rdata = {s_reg.dummy_cnt, 7'h00, s_reg.bank, 3'h0, s_reg.pc};
        end
        else if (s_reg.addr == ADDR_CMD && s_reg.write)
        begin
          // load and add results land in the accumulator, inc writes its result back to the location
          case (op)
            IDA_OP_LOAD:  s_next.acc = rd_val;                   // [RQ10]
            IDA_OP_ADD:   s_next.acc = rd_val + s_reg.acc;       // [RQ10]
            IDA_OP_STORE:
            begin
              wr_en   = 1'b1;
              wr_data = s_reg.acc;
            end
            IDA_OP_INC:
            begin
              wr_en   = 1'b1;
              wr_data = rd_val + 8'h01;                          // [RQ5] [RQ14]
            end
            IDA_OP_JUMP, IDA_OP_CALL:
            begin
              s_next.pc = {s_reg.bank, target[PC_W-2:0]};        // [RQ9]
            end
            default: ;
          endcase
        end

        // writes to specials update state, others go to ram
        if (wr_en)
        begin
          mem_wdata = wr_data;
          if (is_special(eff))
          begin
            case (eff[7:0])
              OFF_PTR0:  s_next.ptr0   = wr_data;                // [RQ5]
              OFF_P1LO:  s_next.p1_lo  = wr_data;
              OFF_P1SEC: s_next.p1_sec = wr_data;
              OFF_P2LO:  s_next.p2_lo  = wr_data;
              OFF_P2SEC: s_next.p2_sec = wr_data;
              OFF_ACC:   s_next.acc    = wr_data;
              OFF_BANK:  s_next.bank   = wr_data[0];             // [RQ7]
              OFF_PCL:
              begin
                s_next.pc    = {s_reg.pc[PC_W-1:PAGE_LSB], wr_data}; // [RQ12]
                s_next.ready = 1'b0;
                s_next.state = IDA_DUMMY;                        // [RQ13]
              end
              default: ;                                         // [RQ4]
            endcase
          end
          else
          begin
            mem_we = 1'b1;
          end
        end
      end

      // one dummy cycle holds the bus after a pc low byte write
      IDA_DUMMY:
      begin
        s_next.ready     = 1'b1;
        s_next.dummy_cnt = s_reg.dummy_cnt + 8'h01;              // [RQ13]
        s_next.state     = IDA_IDLE;
      end

      default:
      begin
        s_next.state = IDA_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_reg           <= '0;
      s_reg.state     <= IDA_IDLE;
      s_reg.ptr0      <= RST_BYTE;
      s_reg.p1_lo     <= RST_BYTE;
      s_reg.p1_sec    <= RST_BYTE;
      s_reg.p2_lo     <= RST_BYTE;
      s_reg.p2_sec    <= RST_BYTE;
      s_reg.acc       <= RST_BYTE;
      s_reg.bank      <= 1'b0;                                   // [RQ7]
      s_reg.pc        <= RST_PC;
      s_reg.dummy_cnt <= RST_BYTE;
      s_reg.ready     <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // general data memory
  // ---------------------------------------------------------------
  ida_dmem u_dmem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign hrdata      = s_reg.rdata;
  assign hreadyout   = s_reg.ready;
  assign hresp       = s_reg.resp;
  assign bank_select = s_reg.bank;
  assign pc_out      = s_reg.pc;

endmodule : ida_core

// ### testbench/ida_core_props.sv
// checker for the indirect addressing core
`timescale 1ns/100ps
module ida_core_props
  import ida_pkg::*;
(
  input wire logic            clk_sys,     // clock
  input wire logic            reset,       // async reset
  input wire logic            hsel,        // select
  input wire logic [31:0]     haddr,       // address
  input wire logic [1:0]      htrans,      // transfer type
  input wire logic            hwrite,      // write
  input wire logic [31:0]     hwdata,      // write data
  input wire logic [31:0]     hrdata,      // read data
  input wire logic            hreadyout,   // ready
  input wire logic            bank_select, // bank
  input wire logic [PC_W-1:0] pc_out       // program counter
);
  // ---------------------------------------------------------------
  // transfer tracking
  // ---------------------------------------------------------------
  logic            busy_q;
  logic            w_q;
  logic [11:0]     a_q;
  logic [31:0]     d_q;
  logic [4:0]      pu_q;
  logic            p0v_q;
  logic [7:0]      p0_q;
  wire             tk  = hsel && htrans[1] && hreadyout;
  wire             rdn = busy_q && hreadyout && !w_q;
  wire             wdn = busy_q && hreadyout && w_q;
  wire [7:0]       of  = a_q[9:2];
  wire             sp  = !a_q[11] && of[7:4] == 4'h0;
  wire             pt  = sp && (of == OFF_PORT0 || of == OFF_PORT1 || of == OFF_PORT2);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // busy from acceptance to completion
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      busy_q <= 1'h0;
    else
      busy_q <= tk || (busy_q && !hreadyout);

  // address, direction, page and data of the transfer in flight
  always_ff @(posedge clk_sys)
    if (tk)
      {a_q, w_q, pu_q} <= {haddr[11:0], hwrite, pc_out[12:8]};
    else if (busy_q && !hreadyout)
      d_q <= hwdata;

  // shadow of pointer_zero: known after reset or a direct write, lost on any
  // write that might reach it through a port or a command
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      {p0v_q, p0_q} <= {1'h1, RST_BYTE};
    else if (wdn && sp && of == OFF_PTR0)
      {p0v_q, p0_q} <= {1'h1, d_q[7:0]};
    else if (wdn && (pt || a_q == ADDR_CMD))
      p0v_q <= 1'h0;

  chk_bank_reset: assert property ($fell(reset) |-> !bank_select && pc_out == RST_PC)
    else $error("bank or pc not clear after reset");
  chk_port_zero: assert property (rdn && sp && of == OFF_PORT0 && p0v_q &&
    (p0_q == OFF_PORT0 || p0_q == OFF_PORT1 || p0_q == OFF_PORT2) |-> hrdata == 32'h0)
    else $error("indirect port read not zero");
  chk_bank_read: assert property (rdn && sp && of == OFF_BANK |->
    hrdata == {31'h0, bank_select})
    else $error("bank register read wrong");
  chk_bank_write: assert property (wdn && sp && of == OFF_BANK |-> bank_select == d_q[0])
    else $error("bank bit not written");
  chk_bank_cause: assert property ($changed(bank_select) |->
    wdn && (sp || a_q == ADDR_CMD))
    else $error("bank bit changed without write");
  chk_pcl_read: assert property (rdn && sp && of == OFF_PCL |->
    hrdata == {24'h0, pc_out[7:0]})
    else $error("pc low byte read wrong");
  chk_pcl_page: assert property (wdn && sp && of == OFF_PCL |->
    pc_out == {pu_q, d_q[7:0]})
    else $error("pc low byte write left page");
  chk_pcl_dummy: assert property (tk && hwrite && !haddr[11] && haddr[9:2] == OFF_PCL |=>
    !hreadyout [*2] ##1 hreadyout)
    else $error("no dummy cycle after pc low write");
  chk_jump_bank: assert property (wdn && a_q == ADDR_CMD && d_q[19:17] == 3'h3 && !d_q[16]
    || wdn && a_q == ADDR_CMD && d_q[19:16] == 4'h5 |-> pc_out == {bank_select, d_q[11:0]})
    else $error("jump missed the selected bank");

  cover property (wdn && a_q == ADDR_CMD);
  cover property (rdn && pt);
  cover property (wdn && sp && of == OFF_PCL);
endmodule : ida_core_props

// ### testbench/ida_core_tb.sv
// self-checking bench for the indirect addressing core
`timescale 1ns/100ps
module ida_core_tb
  import ida_pkg::*;
  ;
  logic            clk_sys, reset, hsel, hwrite, hreadyout, hresp, bank_select, rd_ph;
  logic [31:0]     haddr, hwdata, hrdata;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [PC_W-1:0] pc_out;
  logic [63:0]     exp_q[$];
  logic [63:0]     e;
  logic [7:0]      v, n_dummy;
  logic [7:0]      vs[3];
  int              bad_count, num_checks, seed;
  logic [7:0]      ptr[5] = '{OFF_PTR0, OFF_P1LO, OFF_P1SEC, OFF_P2LO, OFF_P2SEC};
  logic [7:0]      prt[3] = '{OFF_PORT0, OFF_PORT1, OFF_PORT2};
  logic [8:0]      loc[3] = '{9'h080, 9'h190, 9'h091};

  ida_core ida_core_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bank_select(bank_select),
    .pc_out(pc_out));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // one single transfer, read expectation noted when the address is taken
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] want, input logic [31:0] mask);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
    if (!w) exp_q.push_back({mask, want});
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'h1) @(posedge clk_sys);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] want);
    xfer(a, 1'h0, 32'h0, want, 32'hFFFFFFFF);
  endtask : rd

  task automatic stat(input logic b, input logic [12:0] p);
    xfer(ADDR_STAT, 1'h0, 32'h0, {n_dummy, 7'h0, b, 3'h0, p}, 32'hFF011FFF);
  endtask : stat

  task automatic cmd(input ida_op_t op, input logic [12:0] t);
    wr(ADDR_CMD, {12'h0, op, 3'h0, t});
  endtask : cmd

  function automatic logic [11:0] ba(input logic s, input logic [7:0] o);
    return {1'h0, s, o, 2'h0};
  endfunction : ba

  // read data compared with the oldest note
  always @(posedge clk_sys)
  begin
    if (rd_ph && hreadyout === 1'h1)
    begin
      e = exp_q.pop_front();
      check(hrdata & e[63:32], e[31:0]);
      check({31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'h1)
      rd_ph = hsel && htrans[1] && !hwrite && !reset;
  end

  // ---------------------------------------------------------------
  // clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    {reset, hsel, hwrite, rd_ph, htrans, haddr, hwdata} = {1'h1, 69'h0};
    hsize = 3'h2;
    n_dummy = 8'h00;
    seed = 35;
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    stat(1'h0, 13'h0000);
    foreach (ptr[i])
    begin
      v = $random(seed);
      wr(ba(1'(i), ptr[i]), {24'h0, v});
      rd(ba(1'(i + 1), ptr[i]), {24'h0, v});
    end
    wr(ba(1'h0, OFF_P1LO), 32'hFF);
    wr(ba(1'h0, OFF_P1SEC), 32'h0);
    cmd(IDA_OP_INC, 13'h003);
    rd(ba(1'h0, OFF_P1LO), 32'h0);
    rd(ba(1'h0, OFF_P1SEC), 32'h0);
    wr(ba(1'h1, 8'h80), 32'hA5);
    wr(ba(1'h0, OFF_PTR0), 32'h80);
    wr(ba(1'h0, OFF_P1SEC), 32'h1);
    wr(ba(1'h0, OFF_P1LO), 32'h90);
    wr(ba(1'h0, OFF_P2SEC), 32'h0);
    wr(ba(1'h0, OFF_P2LO), 32'h91);
    for (int k = 0; k < 3; k++)
    begin
      vs[k] = $random(seed);
      wr(ba(1'h0, prt[k]), {24'h0, vs[k]});
      rd(ba(loc[k][8], loc[k][7:0]), {24'h0, vs[k]});
      rd(ba(1'h0, prt[k]), {24'h0, vs[k]});
    end
    rd(ba(1'h1, 8'h80), 32'hA5);
    wr(ba(1'h0, OFF_PTR0), 32'h2);
    rd(ba(1'h0, OFF_PORT0), 32'h0);
    wr(ba(1'h0, OFF_PORT0), 32'h77);
    rd(ba(1'h1, 8'h90), {24'h0, vs[1]});
    wr(ba(1'h1, 8'hF0), 32'hC3);
    wr(ba(1'h0, 8'hF0), 32'h5A);
    rd(ba(1'h1, 8'hF0), 32'hC3);
    cmd(IDA_OP_LOAD, 13'h1F0);
    cmd(IDA_OP_ADD, 13'h0F0);
    rd(ba(1'h0, OFF_ACC), {24'h0, 8'(8'hC3 + 8'h5A)});
    cmd(IDA_OP_STORE, 13'h0A0);
    rd(ba(1'h0, 8'hA0), {24'h0, 8'(8'hC3 + 8'h5A)});
    wr(ba(1'h0, OFF_BANK), 32'hFF);
    rd(ba(1'h0, OFF_BANK), 32'h01);
    cmd(IDA_OP_JUMP, 13'h0ABC);
    stat(1'h1, 13'h1ABC);
    wr(ba(1'h0, OFF_PCL), 32'h5A);
    n_dummy++; // one dummy cycle per pc_low_byte write
    stat(1'h1, 13'h1A5A);
    rd(ba(1'h0, OFF_PCL), 32'h5A);
    wr(ba(1'h0, OFF_BANK), 32'h0);
    cmd(IDA_OP_CALL, 13'h1123);
    stat(1'h0, 13'h0123);
    rd(12'h808, 32'h0);
    give_verdict();
  end
endmodule : ida_core_tb

bind ida_core ida_core_props ida_core_props_inst (.clk_sys(clk_sys), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .bank_select(bank_select), .pc_out(pc_out));
